// *** design/acss_pkg.sv ***
// Constants and types shared by the audio codec setup sequencer
package acss_pkg;

  // ---------------------------------------------------------------
  // Clocking and timing
  // ---------------------------------------------------------------
  localparam int SYS_CLK_HZ     = 100_000_000;
  localparam int MCLK_HZ        = 25_000_000;
  localparam int MCLK_HALF_CYC  = SYS_CLK_HZ / (2 * MCLK_HZ);
  localparam logic [1:0] MCLK_HALF_LAST = 2'(MCLK_HALF_CYC - 1);
  localparam int LINK_PERIOD_NS = 15;
  localparam int I2C_QUARTER_NS = 250;   // About 1 MHz bit rate
  localparam int I2C_QUARTER_CYC =
    (I2C_QUARTER_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam logic [7:0] I2C_QUARTER_LAST = 8'(I2C_QUARTER_CYC - 1);
  localparam logic [6:0] CODEC_DEV_ADDR   = 7'h18;

  // ---------------------------------------------------------------
  // Software register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_RATE_LSB  = 4;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_DONE_BIT  = 1;
  localparam int STAT_RERR_BIT  = 2;
  localparam int STAT_NACK_BIT  = 3;
  localparam int STAT_STEP_LSB  = 8;

  // Playback rate selector codes
  localparam logic [2:0] RATE_8K   = 3'h0;
  localparam logic [2:0] RATE_11K  = 3'h1;
  localparam logic [2:0] RATE_16K  = 3'h2;
  localparam logic [2:0] RATE_32K  = 3'h3;
  localparam logic [2:0] RATE_48K  = 3'h4;
  localparam logic [2:0] RATE_64K  = 3'h5;
  localparam logic [2:0] RATE_LAST = 3'h5;

  // ---------------------------------------------------------------
  // Codec register numbers and values
  // ---------------------------------------------------------------
  localparam logic [7:0] CREG_RATE_DIV   = 8'h02;
  localparam logic [7:0] CREG_PLL_A      = 8'h03;
  localparam logic [7:0] CREG_PLL_B      = 8'h04;
  localparam logic [7:0] CREG_PLL_C      = 8'h05;
  localparam logic [7:0] CREG_PLL_D      = 8'h06;
  localparam logic [7:0] CREG_DATAPATH   = 8'h07;
  localparam logic [7:0] CREG_PLL_R      = 8'h0B;
  localparam logic [7:0] CREG_OUT_SWITCH = 8'h29;
  localparam logic [7:0] OUT_SWITCH_DIRECT = 8'hA0;
  localparam logic [7:0] PLL_A_QP_OFF    = 8'h12;
  localparam logic [7:0] PLL_A_ENABLE    = 8'h80;
  localparam logic [7:0] PLL_R_ONE       = 8'h01;
  localparam logic [7:0] DP_BASE         = 8'h0A;
  localparam logic [7:0] DP_FSREF44      = 8'h80;
  localparam logic [7:0] DP_DUAL         = 8'h20;
  localparam logic [5:0] PLL_J44 = 6'h07;
  localparam logic [13:0] PLL_D44 = 14'h08CD;
  localparam logic [5:0] PLL_J48 = 6'h07;
  localparam logic [13:0] PLL_D48 = 14'h21C3;
  localparam logic [3:0] CONVERTER_RATE_DIVIDER_1   = 4'h0;
  localparam logic [3:0] CONVERTER_RATE_DIVIDER_1P5 = 4'h1;
  localparam logic [3:0] CONVERTER_RATE_DIVIDER_3   = 4'h4;
  localparam logic [3:0] CONVERTER_RATE_DIVIDER_4   = 4'h6;
  localparam logic [3:0] CONVERTER_RATE_DIVIDER_6   = 4'hA;
  localparam logic [3:0] LAST_STEP = 4'h8;

  // Sequencer and link states
  typedef enum logic [2:0] {
    SEQ_IDLE  = 3'b001,
    SEQ_ISSUE = 3'b010,
    SEQ_WAIT  = 3'b100
  } acss_seq_t;

  typedef enum logic [3:0] {
    LNK_IDLE  = 4'b0001,
    LNK_START = 4'b0010,
    LNK_BIT   = 4'b0100,
    LNK_STOP  = 4'b1000
  } acss_lnk_t;

endpackage : acss_pkg

// *** design/acss_i2c_link.sv ***
// Two-wire write engine running on the link clock
`timescale 1ns/1ns
`default_nettype none

module acss_i2c_link
  import acss_pkg::*;
(
  // Link clock and raw system reset
  input  wire logic       linkClock,
  input  wire logic       reset,
  // Request from the system domain
  input  wire logic       reqToggle,
  input  wire logic [7:0] wrReg,
  input  wire logic [7:0] wrVal,
  // Completion back to the system domain
  output logic            doneToggle,
  output logic            ackOk,
  // Open-drain pins
  input  wire logic       sclIn,
  output logic            sclOut,
  output logic            sclOe,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe
);

  acss_lnk_t   state_ff;
  logic        rstS1_ff, rstS2_ff, reqS1_ff, reqS2_ff, reqSeen_ff;
  logic        sdaS1_ff, sdaS2_ff, sclS1_ff, sclS2_ff;
  logic [7:0]  qCnt_ff;
  logic [1:0]  phase_ff;
  logic [4:0]  bitIdx_ff;
  logic [26:0] shift_ff;
  logic        sclLow_ff, sdaLow_ff, ackOk_ff, doneTgl_ff, zero_ff;
  logic        tick, stretch, step, ackSlot;

  // ---------------------------------------------------------------
  // Synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge linkClock) begin
    rstS1_ff <= reset;
    rstS2_ff <= rstS1_ff;
    reqS1_ff <= reqToggle;
    reqS2_ff <= reqS1_ff;
    sdaS1_ff <= sdaIn;
    sdaS2_ff <= sdaS1_ff;
    sclS1_ff <= sclIn;
    sclS2_ff <= sclS1_ff;
  end

  // Quarter bit timer and phase stepping
  assign tick    = (qCnt_ff == 8'h00);
  assign stretch = (state_ff == LNK_BIT || state_ff == LNK_STOP) &&
                   (phase_ff == 2'h2) && !sclS2_ff;
  assign step    = tick && !stretch && (state_ff != LNK_IDLE);
  assign ackSlot = (bitIdx_ff == 5'h08) || (bitIdx_ff == 5'h11) ||
                   (bitIdx_ff == 5'h1A);

  always_ff @(posedge linkClock) begin
    if (rstS2_ff || state_ff == LNK_IDLE || tick) begin
      qCnt_ff <= I2C_QUARTER_LAST;
    end else begin
      qCnt_ff <= qCnt_ff - 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // Frame sequencing: start, address, register, value, stop
  // ---------------------------------------------------------------
  always_ff @(posedge linkClock) begin
    if (rstS2_ff) begin
      state_ff   <= LNK_IDLE;
      phase_ff   <= 2'h0;
      bitIdx_ff  <= 5'h00;
      shift_ff   <= 27'h7FFFFFF;
      sclLow_ff  <= 1'b0;
      sdaLow_ff  <= 1'b0;
      ackOk_ff   <= 1'b1;
      doneTgl_ff <= 1'b0;
      reqSeen_ff <= 1'b0;
      zero_ff    <= 1'b0;
    end else begin
      case (state_ff)
        LNK_IDLE: begin
          if (reqS2_ff != reqSeen_ff) begin
            reqSeen_ff <= reqS2_ff;
            shift_ff   <= {CODEC_DEV_ADDR, 1'b0, 1'b1, wrReg, 1'b1,
                           wrVal, 1'b1};
            ackOk_ff   <= 1'b1;
            phase_ff   <= 2'h0;
            state_ff   <= LNK_START;
          end
        end
        LNK_START: begin
          if (step) begin
            phase_ff <= 2'h0;
            if (phase_ff == 2'h0) begin
              sdaLow_ff <= 1'b1;
              phase_ff  <= 2'h1;
            end else begin
              sclLow_ff <= 1'b1;
              bitIdx_ff <= 5'h00;
              state_ff  <= LNK_BIT;
            end
          end
        end
        LNK_BIT: begin
          if (step) begin
            phase_ff <= phase_ff + 2'h1;
            case (phase_ff)
              2'h0: sdaLow_ff <= ~shift_ff[26];
              2'h1: sclLow_ff <= 1'b0;
              2'h2: begin
                if (ackSlot && sdaS2_ff) begin
                  ackOk_ff <= 1'b0;
                end
              end
              default: begin
                sclLow_ff <= 1'b1;
                shift_ff  <= {shift_ff[25:0], 1'b1};
                bitIdx_ff <= bitIdx_ff + 5'h01;
                if (bitIdx_ff == 5'h1A) begin
                  state_ff <= LNK_STOP;
                end
              end
            endcase
          end
        end
        LNK_STOP: begin
          if (step) begin
            phase_ff <= phase_ff + 2'h1;
            case (phase_ff)
              2'h0: sdaLow_ff <= 1'b1;
              2'h1: sclLow_ff <= 1'b0;
              2'h2: sdaLow_ff <= 1'b0;
              default: begin
                doneTgl_ff <= ~doneTgl_ff;
                state_ff   <= LNK_IDLE;
              end
            endcase
          end
        end
        default: state_ff <= LNK_IDLE;
      endcase
    end
  end

  // Open-drain drive: the pins are only ever pulled low
  assign sclOut     = zero_ff;
  assign sdaOut     = zero_ff;
  assign sclOe      = sclLow_ff;
  assign sdaOe      = sdaLow_ff;
  assign doneToggle = doneTgl_ff;
  assign ackOk      = ackOk_ff;

  // Bus released whenever no write is in flight
  link_idle_a: assert property (@(posedge linkClock) disable iff (rstS2_ff)
    (state_ff == LNK_IDLE) |-> (!sdaLow_ff && !sclLow_ff))
    else $error("link drives the bus while idle");

endmodule // acss_i2c_link

`default_nettype wire

// *** design/acss_seq.sv ***
// Codec setup sequencer: register port, write table, master clock
//
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none

// Contract
// - Drive continuous 25 MHz master clock
// - Every setup step is a two-wire write
// - Write 0xA0 to register 41 direct path
// - Write 0x12 to register 3, PLL off
// - Enable PLL only after all PLL writes
// - 44.1 kHz uses Q2 P2 J7 K2253
// - Reference rate is 44.1 or 48 kHz
// - 11.025 kHz writes 0x06 to register 2
// - Per-rate settings; unsupported rates rejected
// - Rates 8,11.025,16,32,48,64 kHz supported
module acss_seq
  import acss_pkg::*;
(
  // System clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // Register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [31:0]      regRdData,
  // Link clock and two-wire pins
  input  wire logic        linkClock,
  input  wire logic        sclIn,
  output logic             sclOut,
  output logic             sclOe,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe,
  // Codec master clock
  output logic             codecMclk
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  acss_seq_t   state_ff;
  logic [3:0]  step_ff;
  logic [2:0]  rate_ff;
  logic [7:0]  linkReg_ff, linkVal_ff;
  logic        reqTgl_ff;
  logic        doneS1_ff, doneS2_ff, doneSeen_ff;
  logic        busy_ff, done_ff, rateErr_ff, nack_ff;
  logic [1:0]  mclkCnt_ff;
  logic        mclk_ff;
  logic [31:0] rdData_ff;
  logic        linkDoneTgl, linkAck, doneEvt;
  logic        ctrlWr, startReq, rateOk;
  logic [2:0]  wrRate;
  logic [15:0] curWord;

  // Table of writes for one setup pass
  function automatic logic [15:0] stepWord(input logic [3:0] step,
                                           input logic [2:0] rate);
    logic        fam44;
    logic [5:0]  j;
    logic [13:0] d;
    logic [3:0]  converter_rate_divider;
    logic [7:0]  dp;
    fam44 = (rate == RATE_11K);
    j     = fam44 ? PLL_J44 : PLL_J48;
    d     = fam44 ? PLL_D44 : PLL_D48;
    dp    = DP_BASE | (fam44 ? DP_FSREF44 : 8'h00) |
            ((rate == RATE_64K) ? DP_DUAL : 8'h00);
    case (rate)
      RATE_8K:  converter_rate_divider = CONVERTER_RATE_DIVIDER_6;
      RATE_11K: converter_rate_divider = CONVERTER_RATE_DIVIDER_4;
      RATE_16K: converter_rate_divider = CONVERTER_RATE_DIVIDER_3;
      RATE_32K: converter_rate_divider = CONVERTER_RATE_DIVIDER_1P5;
      RATE_48K: converter_rate_divider = CONVERTER_RATE_DIVIDER_1;
      RATE_64K: converter_rate_divider = CONVERTER_RATE_DIVIDER_1P5;
      default:  converter_rate_divider = CONVERTER_RATE_DIVIDER_1;
    endcase
    case (step)
      4'h0:    stepWord = {CREG_OUT_SWITCH, OUT_SWITCH_DIRECT};
      4'h1:    stepWord = {CREG_PLL_A, PLL_A_QP_OFF};
      4'h2:    stepWord = {CREG_PLL_B, j, 2'h0};
      4'h3:    stepWord = {CREG_PLL_C, d[13:6]};
      4'h4:    stepWord = {CREG_PLL_D, d[5:0], 2'h0};
      4'h5:    stepWord = {CREG_PLL_R, PLL_R_ONE};
      4'h6:    stepWord = {CREG_DATAPATH, dp};
      4'h7:    stepWord = {CREG_RATE_DIV, 4'h0, converter_rate_divider};
      default: stepWord = {CREG_PLL_A, PLL_A_QP_OFF | PLL_A_ENABLE};
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Register port decode
  // ---------------------------------------------------------------
  assign ctrlWr   = regWr && (regAddr == ADDR_CTRL);
  assign wrRate   = regWrData[CTRL_RATE_LSB +: 3];
  assign startReq = ctrlWr && regWrData[CTRL_START_BIT] &&
                    (state_ff == SEQ_IDLE);
  assign rateOk   = (wrRate <= RATE_LAST);
  assign curWord  = stepWord(step_ff, rate_ff);

  // Rate selector, held while a pass runs
  always_ff @(posedge clock) begin
    if (reset) begin
      rate_ff <= RATE_48K;
    end else if (ctrlWr && state_ff == SEQ_IDLE) begin
      rate_ff <= wrRate;
    end
  end

  // Read data, valid in the cycle after the strobe only
  always_ff @(posedge clock) begin
    if (reset) begin
      rdData_ff <= 32'h00000000;
    end else if (regRd && regAddr == ADDR_CTRL) begin
      rdData_ff <= {25'h0000000, rate_ff, 4'h0};
    end else if (regRd && regAddr == ADDR_STATUS) begin
      rdData_ff <= {20'h00000, step_ff, 4'h0, nack_ff, rateErr_ff,
                    done_ff, busy_ff};
    end else begin
      rdData_ff <= 32'h00000000;
    end
  end

  // ---------------------------------------------------------------
  // Completion crossing from the link domain
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    doneS1_ff <= linkDoneTgl;
    doneS2_ff <= doneS1_ff;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      doneSeen_ff <= 1'b0;
    end else begin
      doneSeen_ff <= doneS2_ff;
    end
  end

  assign doneEvt = (doneS2_ff != doneSeen_ff);

  // ---------------------------------------------------------------
  // Sequencer state machine
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      state_ff <= SEQ_IDLE;
    end else begin
      case (state_ff)
        SEQ_IDLE: begin
          if (startReq && rateOk) begin
            state_ff <= SEQ_ISSUE;
          end
        end
        SEQ_ISSUE: state_ff <= SEQ_WAIT;
        SEQ_WAIT: begin
          if (doneEvt) begin
            if (!linkAck || step_ff == LAST_STEP) begin
              state_ff <= SEQ_IDLE;
            end else begin
              state_ff <= SEQ_ISSUE;
            end
          end
        end
        default: state_ff <= SEQ_IDLE;
      endcase
    end
  end

  // Step index walks the table in fixed order
  always_ff @(posedge clock) begin
    if (reset) begin
      step_ff <= 4'h0;
    end else if (startReq && rateOk) begin
      step_ff <= 4'h0;
    end else if (state_ff == SEQ_WAIT && doneEvt && linkAck &&
                 step_ff != LAST_STEP) begin
      step_ff <= step_ff + 4'h1;
    end
  end

  // Launch one write: latch the word and flip the request toggle on the same edge
  always_ff @(posedge clock) begin
    if (reset) begin
      linkReg_ff <= 8'h00;
      linkVal_ff <= 8'h00;
      reqTgl_ff  <= 1'b0;
    end else if (state_ff == SEQ_ISSUE) begin
      linkReg_ff <= curWord[15:8];
      linkVal_ff <= curWord[7:0];
      reqTgl_ff  <= ~reqTgl_ff;
    end
  end

  // Status flags; done and NACK cleared only by a start written while idle, valid rate or not
  always_ff @(posedge clock) begin
    if (reset) begin
      busy_ff    <= 1'b0;
      done_ff    <= 1'b0;
      rateErr_ff <= 1'b0;
      nack_ff    <= 1'b0;
    end else if (startReq) begin
      busy_ff    <= rateOk;
      done_ff    <= 1'b0;
      rateErr_ff <= !rateOk;
      nack_ff    <= 1'b0;
    end else if (state_ff == SEQ_WAIT && doneEvt) begin
      if (!linkAck) begin
        busy_ff <= 1'b0;
        nack_ff <= 1'b1;
      end else if (step_ff == LAST_STEP) begin
        busy_ff <= 1'b0;
        done_ff <= 1'b1;
      end
    end
  end

  // Master clock divider, free running from reset
  always_ff @(posedge clock) begin
    if (reset) begin
      mclkCnt_ff <= 2'h0;
      mclk_ff    <= 1'b0;
    end else if (mclkCnt_ff == MCLK_HALF_LAST) begin
      mclkCnt_ff <= 2'h0;
      mclk_ff    <= ~mclk_ff;
    end else begin
      mclkCnt_ff <= mclkCnt_ff + 2'h1;
    end
  end

  // ---------------------------------------------------------------
  // Link engine
  // ---------------------------------------------------------------
  acss_i2c_link u_link (
    .linkClock  (linkClock),
    .reset      (reset),
    .reqToggle  (reqTgl_ff),
    .wrReg      (linkReg_ff),
    .wrVal      (linkVal_ff),
    .doneToggle (linkDoneTgl),
    .ackOk      (linkAck),
    .sclIn      (sclIn),
    .sclOut     (sclOut),
    .sclOe      (sclOe),
    .sdaIn      (sdaIn),
    .sdaOut     (sdaOut),
    .sdaOe      (sdaOe)
  );

  assign regRdData = rdData_ff;
  assign codecMclk = mclk_ff;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  mclk_period_a: assert property (@(posedge clock) disable iff (reset)
    $rose(mclk_ff) |=> mclk_ff ##1 !mclk_ff [*2] ##1 mclk_ff)
    else $error("master clock is not a 25 MHz square wave");

  direct_path_a: assert property (@(posedge clock) disable iff (reset)
    (state_ff == SEQ_ISSUE && step_ff == 4'h0) |=>
      (linkReg_ff == 8'h29 && linkVal_ff == 8'hA0))
    else $error("first write is not the direct output path");

  pll_off_a: assert property (@(posedge clock) disable iff (reset)
    (state_ff == SEQ_ISSUE && step_ff == 4'h1) |=>
      (linkReg_ff == 8'h03 && linkVal_ff == 8'h12))
    else $error("PLL register A not written with 0x12");

  pll_late_a: assert property (@(posedge clock) disable iff (reset)
    ($changed(reqTgl_ff) && linkReg_ff == 8'h03 && linkVal_ff[7]) |->
      (step_ff == 4'h8))
    else $error("PLL enabled before its setup is complete");

  pll_k44_a: assert property (@(posedge clock) disable iff (reset)
    (state_ff == SEQ_ISSUE && rate_ff == RATE_11K && step_ff == 4'h3) |=>
      (linkReg_ff == 8'h05 && linkVal_ff == 8'h23))
    else $error("PLL fraction for 44.1 kHz wrong");

  fsref_sel_a: assert property (@(posedge clock) disable iff (reset)
    (state_ff == SEQ_ISSUE && step_ff == 4'h6) |=>
      (linkVal_ff[7] == (rate_ff == RATE_11K)))
    else $error("reference rate family mismatch");

  converter_rate_divider_div4_a: assert property (@(posedge clock) disable iff (reset)
    (state_ff == SEQ_ISSUE && rate_ff == RATE_11K && step_ff == 4'h7) |=>
      (linkReg_ff == 8'h02 && linkVal_ff == 8'h06))
    else $error("11.025 kHz divider not written as 0x06");

  rate_reject_a: assert property (@(posedge clock) disable iff (reset)
    (startReq && wrRate > 3'h5) |=>
      (state_ff == SEQ_IDLE && rateErr_ff && !busy_ff) [*2])
    else $error("unsupported rate was not rejected");

  one_write_a: assert property (@(posedge clock) disable iff (reset)
    (state_ff == SEQ_ISSUE) |=> (state_ff == SEQ_WAIT) [*8])
    else $error("next write issued before completion");

endmodule // acss_seq

`default_nettype wire

// *** verif/acss_codec_model.sv ***
// Behavioural codec slave on the two-wire control link
`timescale 1ns/1ns
`default_nettype none

module acss_codec_model
  import acss_pkg::*;
(
  // Resolved wires
  input  wire logic scl,
  input  wire logic sda,
  // Misbehaviour controls from the bench
  input  wire logic nackAll,
  input  wire logic slow,
  // Pull-low enables
  output logic      sdaPull,
  output logic      sclPull
);
  logic [7:0] shifter;
  logic [7:0] curReg;
  logic [7:0] logReg [0:15];
  logic [7:0] logVal [0:15];
  int         bitCnt;
  int         byteCnt;
  int         nWrites;

  initial begin
    sdaPull = 1'b0;
    sclPull = 1'b0;
    bitCnt = 0;
    byteCnt = 0;
    nWrites = 0;
  end

  // Start condition restarts the framing
  always @(negedge sda) begin
    if (scl) begin
      bitCnt = 0;
      byteCnt = 0;
    end
  end

  // Shift in MSB first while SCL rises
  always @(posedge scl) begin
    if (bitCnt < 8) begin
      shifter = {shifter[6:0], sda};
      bitCnt++;
    end
  end

  // Acknowledge slot after each byte, log complete writes
  always @(negedge scl) begin
    if (bitCnt == 9) begin
      sdaPull <= 1'b0;
      bitCnt = 0;
      byteCnt++;
    end else if (bitCnt == 8) begin
      if (byteCnt == 1) curReg = shifter;
      if (byteCnt == 2 && nWrites < 16 && !nackAll) begin
        logReg[nWrites] = curReg;
        logVal[nWrites] = shifter;
        nWrites++;
      end
      sdaPull <= !nackAll && (byteCnt > 0 || shifter == {CODEC_DEV_ADDR, 1'b0});
      bitCnt = 9;
    end
  end

  // Slow answer: stretch every low phase of SCL
  always @(negedge scl) begin
    if (slow) begin
      sclPull <= 1'b1;
      #900;  // Past the sample quarter, so every bit is stretched
      sclPull <= 1'b0;
    end
  end
endmodule // acss_codec_model

`default_nettype wire

// *** verif/test_audio_codec_setup_sequencer.sv ***
// Self-checking bench for the codec setup sequencer
`timescale 1ns/1ns
`default_nettype none

`define CHK(got, exp) \
  begin \
    nCompared++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
    end \
  end

module test_audio_codec_setup_sequencer
  import acss_pkg::*;
;
  typedef struct packed {
    logic [7:0]  wa;
    logic [31:0] wd;
    logic [7:0]  ra;
    logic [31:0] mask;
    logic [31:0] exp;
  } acss_row_t;

  localparam logic [31:0] SBUSY = 32'h1 << STAT_BUSY_BIT;
  localparam logic [31:0] SDONE = 32'h1 << STAT_DONE_BIT;
  localparam logic [31:0] SERR  = 32'h1 << STAT_RERR_BIT;
  localparam logic [31:0] SNACK = 32'h1 << STAT_NACK_BIT;
  localparam logic [31:0] SMASK = SBUSY | SDONE | SERR | SNACK;
  localparam logic [13:0] K44   = 14'h08CD;

  logic        clock = 1'b0;
  logic        linkClock = 1'b0;
  logic        reset;
  logic [7:0]  regAddr;
  logic [31:0] regWrData;
  logic        regWr;
  logic        regRd;
  logic [31:0] regRdData;
  logic        sclOut;
  logic        sclOe;
  logic        sdaOut;
  logic        sdaOe;
  logic        codecMclk;
  logic        mSda;
  logic        mScl;
  logic        nackAll;
  logic        slow;
  logic        sclW;
  logic        sdaW;
  logic        prev;
  logic [31:0] rd;
  logic [15:0] wrLog;
  int          errors = 0;
  int          nCompared = 0;
  int          i;

  // Ordinary register cases
  acss_row_t rows [0:4] = '{
    '{ADDR_CTRL, 32'h30, ADDR_CTRL, 32'h70, 32'h30},
    '{ADDR_CTRL, 32'h61, ADDR_STATUS, SMASK, SERR},
    '{ADDR_CTRL, 32'h71, ADDR_STATUS, SMASK, SERR},
    '{ADDR_STATUS, 32'h0F, ADDR_STATUS, SMASK, SERR},
    '{8'h08, 32'hFFFFFFFF, 8'h08, 32'hFFFFFFFF, 32'h0}
  };
  // Register number and value of each write of an 11.025 kHz pass
  logic [15:0] expWr [0:8] = '{16'h29A0, 16'h0312, 16'h041C,
    {8'h05, K44[13:6]}, {8'h06, K44[5:0], 2'b00}, 16'h0B01,
    16'h078A, 16'h0206, 16'h0392};

  // Clocks and open-drain wires with pull-ups
  always #5 clock = !clock;
  always begin
    #7 linkClock = 1'b1;
    #8 linkClock = 1'b0;
  end
  assign sclW = (sclOe ? sclOut : 1'b1) & !mScl;
  assign sdaW = (sdaOe ? sdaOut : 1'b1) & !mSda;

  acss_seq i_acss_seq (
    .clock     (clock),
    .reset     (reset),
    .regAddr   (regAddr),
    .regWrData (regWrData),
    .regWr     (regWr),
    .regRd     (regRd),
    .regRdData (regRdData),
    .linkClock (linkClock),
    .sclIn     (sclW),
    .sclOut    (sclOut),
    .sclOe     (sclOe),
    .sdaIn     (sdaW),
    .sdaOut    (sdaOut),
    .sdaOe     (sdaOe),
    .codecMclk (codecMclk)
  );

  acss_codec_model i_acss_codec_model (
    .scl     (sclW),
    .sda     (sdaW),
    .nackAll (nackAll),
    .slow    (slow),
    .sdaPull (mSda),
    .sclPull (mScl)
  );

  task automatic closeOut();
    if (errors == 0 && nCompared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clock);
    regWr <= 1'b0;
  endtask

  task automatic rdReg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    #1;
    d = regRdData;
  endtask

  // Poll status until the pass is over, bounded
  task automatic waitIdle();
    int k;
    for (k = 0; k < 60; k++) begin
      repeat (1000) @(posedge clock);
      rdReg(ADDR_STATUS, rd);
      if (rd[STAT_BUSY_BIT] === 1'b0) return;
    end
    errors++;
    closeOut();
  endtask

  initial begin
    reset = 1'b1;
    regAddr = 8'h00;
    regWrData = 32'h0;
    regWr = 1'b0;
    regRd = 1'b0;
    nackAll = 1'b0;
    slow = 1'b0;
    repeat (10) @(posedge clock);
    `CHK(regRdData, 32'h0)
    `CHK({sclOe, sdaOe, sclOut, sdaOut}, 4'h0)
    `CHK(codecMclk, 1'b0)
    reset <= 1'b0;
    repeat (4) @(posedge clock);
    // Master clock: two cycles high, two low
    prev = 1'b1;
    for (i = 0; i < 12 && !(prev === 1'b0 && codecMclk === 1'b1); i++) begin
      prev = codecMclk;
      @(posedge clock);
      #1;
    end
    for (i = 0; i < 16; i++) begin
      @(posedge clock);
      #1;
      `CHK(codecMclk, ((i + 1) % 4) < 2)
    end
    for (i = 0; i < 5; i++) begin
      wr(rows[i].wa, rows[i].wd);
      rdReg(rows[i].ra, rd);
      `CHK(rd & rows[i].mask, rows[i].exp)
    end
    // Full pass with a slow codec; a start while busy is ignored
    slow <= 1'b1;
    wr(ADDR_CTRL, {25'h0, RATE_11K, 4'h1});
    rdReg(ADDR_STATUS, rd);
    `CHK(rd & SMASK, SBUSY)
    wr(ADDR_CTRL, {25'h0, RATE_64K, 4'h1});
    waitIdle();
    `CHK(rd & SMASK, SDONE)
    `CHK(rd[STAT_STEP_LSB +: 4], 4'h8)
    rdReg(ADDR_CTRL, rd);
    `CHK(rd[6:4], RATE_11K)
    `CHK(i_acss_codec_model.nWrites, 9)
    for (i = 0; i < 9; i++) begin
      wrLog = {i_acss_codec_model.logReg[i], i_acss_codec_model.logVal[i]};
      `CHK(wrLog, expWr[i])
    end
    // Codec refuses: pass aborts after the first frame
    slow <= 1'b0;
    nackAll <= 1'b1;
    wr(ADDR_CTRL, {25'h0, RATE_48K, 4'h1});
    waitIdle();
    `CHK(rd & SMASK, SNACK)
    `CHK(i_acss_codec_model.nWrites, 9)
    // Reset in mid pass
    nackAll <= 1'b0;
    wr(ADDR_CTRL, {25'h0, RATE_8K, 4'h1});
    repeat (50) @(posedge clock);
    reset <= 1'b1;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    rdReg(ADDR_STATUS, rd);
    `CHK(rd & SMASK, 32'h0)
    `CHK({sclOe, sdaOe}, 2'b00)
    closeOut();
  end
endmodule // test_audio_codec_setup_sequencer

`default_nettype wire
